// *** src/twmr_top.sv ***
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "twmr_regs.svh"
module twmr_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);
  logic scl_s;
  logic sda_s;
  twmr_sync u_scl (.aclk(aclk), .aresetn(aresetn), .din(scl_i), .dout(scl_s));
  twmr_sync u_sda (.aclk(aclk), .aresetn(aresetn), .din(sda_i), .dout(sda_s));

  // Bus activity tracking from sampled lines
  logic scl_d, sda_d, busy, next_busy;
  always_comb begin
    next_busy = busy;
    if (scl_s && scl_d && sda_d && !sda_s) next_busy = 1'b1;
    if (scl_s && scl_d && !sda_d && sda_s) next_busy = 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      busy <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      busy <= next_busy;
    end
  end

  // Quarter bit tick divider
  logic [7:0] div, next_div;
  logic tick;
  always_comb begin
    tick = (div == 8'(`TWMR_QTR_CYCLES - 1));
    next_div = tick ? 8'h00 : div + 8'h01;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) div <= 8'h00;
    else div <= next_div;
  end

  // Register state
  logic int_f, ea, sta, sto, wc, en, ie;
  logic [7:0] status, data;
  logic [1:0] irq_st, irq_mask;
  logic aw_h, w_h;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  logic next_aw_h, next_w_h;
  logic [7:0] next_aw_a;
  logic [31:0] next_w_d;
  logic [3:0] next_w_s;
  logic next_bvalid, next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_bresp, next_rresp;
  logic wr_go;
  // Protocol engine state
  twmr_pkg::twmr_state_t fsm, next_fsm;
  twmr_pkg::twmr_phase_t ph, next_ph;
  logic [3:0] bitn, next_bitn;
  logic [7:0] sh, next_sh;
  logic rx, next_rx, rx_ack, next_rx_ack, then_start, next_then_start;
  logic next_scl_o, next_sda_o;
  logic hw_int, hw_sto_clr, hw_wc;
  logic [7:0] hw_status;

  function automatic logic [31:0] twmr_rd(input logic [7:0] a, input logic [31:0] ctl,
                                          input logic [7:0] s, input logic [7:0] d,
                                          input logic [1:0] is, input logic [1:0] im);
    case (a)
      `TWMR_OFF_CONTROL: twmr_rd = ctl;
      `TWMR_OFF_STATUS: twmr_rd = {24'h000000, s};
      `TWMR_OFF_DATA: twmr_rd = {24'h000000, d};
      `TWMR_OFF_IRQ_STATUS: twmr_rd = {30'h00000000, is};
      `TWMR_OFF_IRQ_MASK: twmr_rd = {30'h00000000, im};
      default: twmr_rd = 32'h00000000;
    endcase
  endfunction : twmr_rd

  function automatic logic twmr_mapped(input logic [7:0] a);
    twmr_mapped = (a == `TWMR_OFF_CONTROL) || (a == `TWMR_OFF_STATUS) ||
                  (a == `TWMR_OFF_DATA) || (a == `TWMR_OFF_IRQ_STATUS) ||
                  (a == `TWMR_OFF_IRQ_MASK);
  endfunction : twmr_mapped

  logic next_int, next_ea, next_sta, next_sto, next_wc, next_en, next_ie;
  logic [7:0] next_status, next_data;
  logic [1:0] next_irq_st, next_irq_mask;
  logic next_irq;
  logic [31:0] ctl_word;
  assign ctl_word = {24'h000000, int_f, ea, sta, sto, wc, en, 1'b0, ie};

  // AXI slave and register file
  always_comb begin
    next_aw_h = aw_h;
    next_w_h = w_h;
    next_aw_a = aw_a;
    next_w_d = w_d;
    next_w_s = w_s;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_int = int_f;
    next_ea = ea;
    next_sta = sta;
    next_sto = sto;
    next_wc = wc;
    next_en = en;
    next_ie = ie;
    next_status = hw_status;
    next_data = data;
    next_irq_st = irq_st;
    next_irq_mask = irq_mask;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_h = 1'b1;
      next_aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_h = 1'b1;
      next_w_d = s_axi_wdata;
      next_w_s = s_axi_wstrb;
    end
    wr_go = aw_h && w_h && !s_axi_bvalid;
    if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (wr_go) begin
      next_aw_h = 1'b0;
      next_w_h = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = twmr_mapped(aw_a) ? 2'b00 : 2'b10;
      if (w_s[0]) begin
        case (aw_a)
          `TWMR_OFF_CONTROL: begin
            if (w_d[`TWMR_BIT_INT]) next_int = 1'b0;
            next_ea = w_d[`TWMR_BIT_EA];
            next_sta = w_d[`TWMR_BIT_STA];
            next_sto = w_d[`TWMR_BIT_STO];
            next_en = w_d[`TWMR_BIT_EN];
            next_ie = w_d[`TWMR_BIT_IE];
          end
          `TWMR_OFF_DATA: begin
            if (int_f) next_data = w_d[7:0];
            else next_wc = 1'b1;
          end
          `TWMR_OFF_IRQ_STATUS: next_irq_st = irq_st & ~w_d[1:0];
          `TWMR_OFF_IRQ_MASK: next_irq_mask = w_d[1:0];
          default: next_irq_mask = irq_mask;
        endcase
      end
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = twmr_rd(s_axi_araddr, ctl_word, status, data, irq_st, irq_mask);
      next_rresp = twmr_mapped(s_axi_araddr) ? 2'b00 : 2'b10;
    end
    // Hardware sets win over software clears, but a cleared EN wins over both for INT, STA and STO
    if (hw_int) begin
      next_int = 1'b1;
      next_irq_st[0] = 1'b1;
      if (rx) next_data = sh;
    end
    if (hw_wc) next_irq_st[1] = 1'b1;
    if (hw_sto_clr) next_sto = 1'b0;
    if (!next_en) begin
      next_int = 1'b0;
      next_sta = 1'b0;
      next_sto = 1'b0;
    end
    next_irq = |(next_irq_st & next_irq_mask) || (next_int && next_ie);
  end

  // Transfer engine
  always_comb begin
    next_fsm = fsm;
    next_ph = ph;
    next_bitn = bitn;
    next_sh = sh;
    next_rx = rx;
    next_rx_ack = rx_ack;
    next_then_start = then_start;
    next_scl_o = scl_o;
    next_sda_o = sda_o;
    hw_int = 1'b0;
    hw_sto_clr = 1'b0;
    hw_wc = 1'b0;
    hw_status = status;
    if (!en) begin
      next_fsm = twmr_pkg::TWMR_IDLE;
      next_scl_o = 1'b1;
      next_sda_o = 1'b1;
      hw_status = `TWMR_CODE_IDLE;
    end else if (tick) begin
      next_ph = twmr_pkg::twmr_phase_t'(ph + 2'b01);
      case (fsm)
        twmr_pkg::TWMR_IDLE: begin
          next_ph = twmr_pkg::TWMR_PH0;
          if (sta && !int_f) next_fsm = twmr_pkg::TWMR_WAIT_FREE;
        end
        twmr_pkg::TWMR_WAIT_FREE: begin
          next_ph = twmr_pkg::TWMR_PH0;
          if (!busy) next_fsm = twmr_pkg::TWMR_START;
        end
        twmr_pkg::TWMR_START, twmr_pkg::TWMR_RESTART: begin
          if (ph == twmr_pkg::TWMR_PH0) begin
            next_sda_o = 1'b1;
            next_scl_o = 1'b1;
          end else if (ph == twmr_pkg::TWMR_PH2) next_sda_o = 1'b0;
          else if (ph == twmr_pkg::TWMR_PH3) begin
            next_scl_o = 1'b0;
            hw_int = 1'b1;
            hw_status = (fsm == twmr_pkg::TWMR_START) ? `TWMR_CODE_START : `TWMR_CODE_RSTART;
            next_rx = 1'b0;
            next_fsm = twmr_pkg::TWMR_HOLD;
          end
        end
        twmr_pkg::TWMR_HOLD: begin
          next_ph = twmr_pkg::TWMR_PH0;
          if (!int_f) begin
            if (status == `TWMR_CODE_START || status == `TWMR_CODE_RSTART) begin
              next_sh = data;
              next_rx = 1'b0;
              next_bitn = 4'h0;
              next_fsm = twmr_pkg::TWMR_BIT;
            end else if (status == `TWMR_CODE_ARB) begin
              next_scl_o = 1'b1;
              next_sda_o = 1'b1;
              next_fsm = sta ? twmr_pkg::TWMR_WAIT_FREE : twmr_pkg::TWMR_IDLE;
            end else if ((status == `TWMR_CODE_ADR_ACK) || (status == `TWMR_CODE_DAT_ACK)) begin
              next_rx = 1'b1;
              next_sh = 8'h00;
              next_bitn = 4'h0;
              next_fsm = twmr_pkg::TWMR_BIT;
            end else if (sto) begin
              next_then_start = sta;
              next_fsm = twmr_pkg::TWMR_STOP;
            end else if (sta) next_fsm = twmr_pkg::TWMR_RESTART;
          end
        end
        twmr_pkg::TWMR_BIT: begin
          if (ph == twmr_pkg::TWMR_PH0) next_sda_o = rx ? 1'b1 : sh[7];
          else if (ph == twmr_pkg::TWMR_PH1) next_scl_o = 1'b1;
          else if (ph == twmr_pkg::TWMR_PH2) begin
            if (!scl_s) next_ph = ph; // slave stretching
            else if (!rx && sh[7] && !sda_s) begin
              next_fsm = twmr_pkg::TWMR_HOLD;
              next_scl_o = 1'b0;
              next_sda_o = 1'b1;
              hw_int = 1'b1;
              hw_status = `TWMR_CODE_ARB;
            end else next_sh = {sh[6:0], sda_s};
          end else begin
            next_scl_o = 1'b0;
            next_bitn = bitn + 4'h1;
            if (bitn == 4'h7) next_fsm = twmr_pkg::TWMR_ACK;
          end
        end
        twmr_pkg::TWMR_ACK: begin
          if (ph == twmr_pkg::TWMR_PH0) next_sda_o = rx ? !ea : 1'b1;
          else if (ph == twmr_pkg::TWMR_PH1) next_scl_o = 1'b1;
          else if (ph == twmr_pkg::TWMR_PH2) begin
            if (!scl_s) next_ph = ph;
            else next_rx_ack = !sda_s;
          end else begin
            next_scl_o = 1'b0;
            next_fsm = twmr_pkg::TWMR_HOLD;
            hw_int = 1'b1;
            if (rx) hw_status = sda_o ? `TWMR_CODE_DAT_NACK : `TWMR_CODE_DAT_ACK;
            else if (!data[0]) hw_status = rx_ack ? `TWMR_CODE_TX_ACK : `TWMR_CODE_DAT_NACK;
            else hw_status = rx_ack ? `TWMR_CODE_ADR_ACK : `TWMR_CODE_ADR_NACK;
            if (rx) begin
              next_sda_o = 1'b1;
            end
          end
        end
        twmr_pkg::TWMR_STOP: begin
          if (ph == twmr_pkg::TWMR_PH0) next_sda_o = 1'b0;
          else if (ph == twmr_pkg::TWMR_PH1) next_scl_o = 1'b1;
          else if (ph == twmr_pkg::TWMR_PH2) next_sda_o = 1'b1;
          else begin
            hw_sto_clr = 1'b1;
            next_fsm = then_start ? twmr_pkg::TWMR_WAIT_FREE : twmr_pkg::TWMR_IDLE;
          end
        end
        default: next_fsm = twmr_pkg::TWMR_IDLE;
      endcase
    end
    if (wr_go && aw_a == `TWMR_OFF_DATA && w_s[0] && !int_f) hw_wc = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h <= 1'b0;
      w_h <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 32'h00000000;
      w_s <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
      int_f <= 1'b0;
      ea <= 1'b0;
      sta <= 1'b0;
      sto <= 1'b0;
      wc <= 1'b0;
      en <= 1'b0;
      ie <= 1'b0;
      status <= `TWMR_CODE_IDLE;
      data <= 8'hFF;
      irq_st <= 2'b00;
      irq_mask <= 2'b00;
      irq <= 1'b0;
      fsm <= twmr_pkg::TWMR_IDLE;
      ph <= twmr_pkg::TWMR_PH0;
      bitn <= 4'h0;
      sh <= 8'h00;
      rx <= 1'b0;
      rx_ack <= 1'b0;
      then_start <= 1'b0;
      scl_o <= 1'b1;
      sda_o <= 1'b1;
    end else begin
      aw_h <= next_aw_h;
      w_h <= next_w_h;
      aw_a <= next_aw_a;
      w_d <= next_w_d;
      w_s <= next_w_s;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      int_f <= next_int;
      ea <= next_ea;
      sta <= next_sta;
      sto <= next_sto;
      wc <= next_wc;
      en <= next_en;
      ie <= next_ie;
      status <= next_status;
      data <= next_data;
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
      fsm <= next_fsm;
      ph <= next_ph;
      bitn <= next_bitn;
      sh <= next_sh;
      rx <= next_rx;
      rx_ack <= next_rx_ack;
      then_start <= next_then_start;
      scl_o <= next_scl_o;
      sda_o <= next_sda_o;
    end
  end

  // Ready flags and open-drain enables from flops
  logic awr_q, wr_q, arr_q, scl_oe_q, sda_oe_q;
  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_arready = arr_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      arr_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      // New write held off until the pending response is taken
      awr_q <= !next_aw_h && !next_bvalid && !(s_axi_awvalid && awr_q);
      wr_q <= !next_w_h && !next_bvalid && !(s_axi_wvalid && wr_q);
      arr_q <= !next_rvalid && !(s_axi_arvalid && arr_q);
      scl_oe_q <= !next_scl_o;
      sda_oe_q <= !next_sda_o;
    end
  end
endmodule : twmr_top

// *** src/twmr_regs.svh ***
`ifndef TWMR_REGS_SVH
`define TWMR_REGS_SVH
`define TWMR_OFF_CONTROL 8'h00
`define TWMR_OFF_STATUS 8'h04
`define TWMR_OFF_DATA 8'h08
`define TWMR_OFF_IRQ_STATUS 8'h0C
`define TWMR_OFF_IRQ_MASK 8'h10
`define TWMR_BIT_INT 7
`define TWMR_BIT_EA 6
`define TWMR_BIT_STA 5
`define TWMR_BIT_STO 4
`define TWMR_BIT_WC 3
`define TWMR_BIT_EN 2
`define TWMR_BIT_IE 0
`define TWMR_CODE_START 8'h08
`define TWMR_CODE_RSTART 8'h10
`define TWMR_CODE_ARB 8'h38
`define TWMR_CODE_ADR_ACK 8'h40
`define TWMR_CODE_ADR_NACK 8'h48
`define TWMR_CODE_DAT_ACK 8'h50
`define TWMR_CODE_DAT_NACK 8'h58
`define TWMR_CODE_TX_ACK 8'h18
`define TWMR_CODE_IDLE 8'hF8
`define TWMR_CLK_HZ 25000000
`define TWMR_SCL_HZ 100000
`define TWMR_QTR_CYCLES ((`TWMR_CLK_HZ / `TWMR_SCL_HZ) / 4)
`endif

// *** src/twmr_pkg.sv ***
package twmr_pkg;
  typedef enum logic [3:0] {
    TWMR_IDLE = 4'b0000,
    TWMR_WAIT_FREE = 4'b0001,
    TWMR_START = 4'b0010,
    TWMR_HOLD = 4'b0011,
    TWMR_BIT = 4'b0100,
    TWMR_ACK = 4'b0101,
    TWMR_STOP = 4'b0110,
    TWMR_RESTART = 4'b0111
  } twmr_state_t;
  typedef enum logic [1:0] {
    TWMR_PH0 = 2'b00,
    TWMR_PH1 = 2'b01,
    TWMR_PH2 = 2'b10,
    TWMR_PH3 = 2'b11
  } twmr_phase_t;
endpackage : twmr_pkg

// *** src/twmr_sync.sv ***
`timescale 1ns/10ps
module twmr_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  logic meta;
  logic next_meta;
  logic next_dout;
  always_comb begin
    next_meta = din;
    next_dout = meta;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end
endmodule : twmr_sync

// *** testbench/twmr_sva.sv ***
`timescale 1ns/10ps
module twmr_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  a_reset_quiet: assert property (!aresetn |=> !s_axi_awready && !s_axi_arready && !s_axi_bvalid
    && !s_axi_rvalid && !irq && !scl_oe && !sda_oe) else $error("active after reset");
  a_bvalid_hold: assert property (disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rvalid_hold: assert property (disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid");
  a_read_answer: assert property (disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read answer");
  a_write_blocks: assert property (disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_scl_drain: assert property (disable iff (!aresetn)
    scl_oe |-> !scl_o) else $error("scl driven high");
  a_sda_drain: assert property (disable iff (!aresetn)
    sda_oe |-> !sda_o) else $error("sda driven high");
  a_start_free: assert property (disable iff (!aresetn)
    $rose(sda_oe) && !scl_oe |-> $past(sda_i)) else $error("start on busy bus");
  a_scl_high_min: assert property (disable iff (!aresetn)
    $fell(scl_oe) |=> !scl_oe [*8]) else $error("scl high too short");
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_irq: cover property ($rose(irq));
endmodule : twmr_sva
bind twmr_top twmr_sva twmr_sva_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .irq);

// *** testbench/twmr_slave.sv ***
`timescale 1ns/10ps
module twmr_slave #(parameter logic [6:0] ADDR = 7'h2A) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] tx_data,
  output logic sda_oe
);
  logic ack = 1'b0;
  logic snd = 1'b0;
  logic m;
  logic [7:0] sh;
  int n = 0;
  // Pulls low only; data follows tx_data live while the clock is stalled
  assign sda_oe = ack || (snd && !tx_data[3'(7 - n)]);
  initial forever begin
    @(negedge sda iff scl === 1'b1);
    for (n = 0; n < 8; n++) begin
      @(posedge scl);
      sh[3'(7 - n)] = sda;
    end
    n = 0;
    @(negedge scl);
    if (sh == {ADDR, 1'b1}) begin
      ack = 1'b1;
      @(negedge scl);
      ack = 1'b0;
      do begin
        snd = 1'b1;
        for (n = 0; n < 7; n++) @(negedge scl);
        @(negedge scl);
        snd = 1'b0;
        @(posedge scl);
        m = sda;
        @(negedge scl);
        n = 0;
      end while (!m);
    end
  end
endmodule : twmr_slave

// *** testbench/test_twmr_top.sv ***
`timescale 1ns/10ps
module test_twmr_top;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} twmr_exp_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic hold = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic scl_o, scl_oe, sda_o, sda_oe, irq, sl_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, q;
  logic [7:0] b;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  twmr_exp_t rq[$];
  logic [1:0] bq[$];
  twmr_exp_t e;
  wire scl_i = !scl_oe;
  wire sda_i = !(sda_oe || sl_oe || hold);
  twmr_top twmr_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .irq);
  twmr_slave twmr_slave_i (.scl(scl_i), .sda(sda_i), .tx_data(tx_data), .sda_oe(sl_oe));
  always #20 aclk = ~aclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                    input logic [1:0] r, output logic [31:0] v);
    rq.push_back('{x, m, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic poll;
    do rd(8'h00, 32'h0, 32'h0, 2'b00, q); while (q[7] !== 1'b1);
    check(scl_i, 1'b0);
  endtask : poll
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      if (e.m !== 32'h0) check(s_axi_rdata & e.m, e.d);
      check(32'(s_axi_rresp), 32'(e.r));
    end
    if (s_axi_bvalid && s_axi_bready) check(32'(s_axi_bresp), 32'(bq.pop_front()));
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    void'($urandom(78505));
    rd(8'h04, 32'hFF, 32'hF8, 2'b00, q);
    rd(8'h20, 32'hFFFFFFFF, 32'h0, 2'b10, q);
    wr(8'h20, 32'h1, 2'b10);
    wr(8'h10, 32'h0, 2'b00);
    wr(8'h00, 32'h04, 2'b00);
    wr(8'h08, 32'h12, 2'b00);
    rd(8'h00, 32'h08, 32'h08, 2'b00, q);
    rd(8'h0C, 32'h02, 32'h02, 2'b00, q);
    wr(8'h0C, 32'h3, 2'b00);
    hold <= 1'b1;
    wr(8'h00, 32'hA4, 2'b00);
    repeat (1500) @(posedge aclk);
    rd(8'h00, 32'h80, 32'h00, 2'b00, q);
    hold <= 1'b0;
    poll;
    rd(8'h04, 32'hFF, 32'h08, 2'b00, q);
    check(irq, 1'b0);
    wr(8'h10, 32'h1, 2'b00);
    repeat (3) @(posedge aclk);
    check(irq, 1'b1);
    wr(8'h0C, 32'h1, 2'b00);
    repeat (3) @(posedge aclk);
    check(irq, 1'b0);
    wr(8'h08, 32'h55, 2'b00);
    wr(8'h00, 32'hC4, 2'b00);
    poll;
    rd(8'h04, 32'hFF, 32'h40, 2'b00, q);
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      tx_data <= b;
      wr(8'h00, (i == 2) ? 32'h84 : 32'hC4, 2'b00);
      poll;
      rd(8'h04, 32'hFF, (i == 2) ? 32'h58 : 32'h50, 2'b00, q);
      rd(8'h08, 32'hFF, {24'h0, b}, 2'b00, q);
    end
    wr(8'h00, 32'hA4, 2'b00);
    poll;
    rd(8'h04, 32'hFF, 32'h10, 2'b00, q);
    wr(8'h08, 32'hEF, 2'b00);
    wr(8'h00, 32'h84, 2'b00);
    poll;
    rd(8'h04, 32'hFF, 32'h48, 2'b00, q);
    wr(8'h00, 32'hB4, 2'b00);
    poll;
    rd(8'h04, 32'hFF, 32'h08, 2'b00, q);
    rd(8'h00, 32'h10, 32'h00, 2'b00, q);
    wr(8'h08, 32'hEF, 2'b00);
    wr(8'h00, 32'h84, 2'b00);
    poll;
    rd(8'h04, 32'hFF, 32'h48, 2'b00, q);
    wr(8'h00, 32'h94, 2'b00);
    do rd(8'h00, 32'h0, 32'h0, 2'b00, q); while (q[4] !== 1'b0);
    check({scl_i, sda_i}, 2'b11);
    wrap_up;
  end
endmodule : test_twmr_top
